// ---- verilog/ext_irq_ctrl.sv ----
// Purpose: external irq zero sense logic and pin-change group requests
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   requests to the core need the global flag from the core
//
// What this block does
// - Sense field 00 is low level, 01 any change, 10 falling, 11 rising.
// - The irq zero pin is synchronised before any edge detection.
// - Any pulse longer than one clock period gives a request in edge modes.
// - The irq zero request goes out only with its enable and global flag.
// - The sense register has bits 1:0 writable, the rest read zero.
// - The mask register has group enables at bits 7, 6 and irq zero at 0.
// - Group 1 raises on a change of any enabled source 15 to 8.
// - Group 0 raises on a change of any enabled source 7 to 0.
// - Each source passes its own mask bit before the group enable.
// - Port E bits 0 to 2 are sources 0 to 2 whatever their use.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "irq_sense_defs.svh"
module ext_irq_ctrl
	import irq_sense_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ext_irq_zero,
	input  wire logic        port_e_bit0,
	input  wire logic        port_e_bit1,
	input  wire logic        port_e_bit2,
	input  wire logic [15:3] pin_change_source,
	input  wire logic        global_irq_flag,
	output logic             ext_irq_zero_req,
	output logic             pin_change_group0_vector,
	output logic             pin_change_group1_vector,
	output logic             irq
);
	reg_byte_t   ext_irq_mask;
	reg_byte_t   ext_irq_sense_ctrl;
	reg_byte_t   pin_change_mask_lo;
	reg_byte_t   pin_change_mask_hi;
	reg_byte_t   irq_status;
	reg_byte_t   irq_enable;
	reg_byte_t   next_status;
	reg_byte_t   status_set;
	reg_byte_t   status_clr;
	reg_byte_t   read_value;

	logic        addr_phase;
	logic        wr_pending;
	logic [9:0]  wr_index;
	logic [9:0]  rd_index;
	logic        wr_go;
	logic [7:0]  wr_byte;

	logic [15:0] all_sources;
	logic [15:0] pin_mask;
	logic        zero_event;
	logic        group0_change;
	logic        group1_change;
	sense_mode_t sense_mode;

	// Word index of a byte address; upper bits must be clear to hit
	function automatic logic [9:0] word_index(input logic [31:0] addr);
		word_index = addr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
	endfunction

	function automatic logic hits(input logic [31:0] addr,
			input logic [9:0] index);
		hits = (addr[31:`ADDR_IDX_MSB+1] == '0) &&
			(addr[1:0] == 2'h0) && (word_index(addr) == index);
	endfunction

	// Bus request decode

	assign addr_phase = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
	assign wr_go      = wr_pending && clk_en;
	assign wr_byte    = hwdata[7:0];

	always_comb begin
		rd_index = word_index(haddr);
		if (!hits(haddr, rd_index))
			rd_index = 10'h3ff;
	end

	// Address phase of a write is kept for its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending <= 1'b0;
			wr_index   <= 10'h3ff;
		end else if (clk_en) begin
			if (addr_phase && hwrite && hsize == `HSIZE_WORD) begin
				wr_pending <= 1'b1;
				wr_index   <= rd_index;
			end else if (hready) begin
				wr_pending <= 1'b0;
			end
		end
	end

	// Zero wait states; every transfer answers OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= `HRESP_OKAY;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp     <= `HRESP_OKAY;
		end
	end

	always_comb begin
		read_value = 8'h00;
		unique case (rd_index)
			`EXT_IRQ_MASK_IDX:       read_value = ext_irq_mask;
			`EXT_IRQ_SENSE_CTRL_IDX: read_value = ext_irq_sense_ctrl;
			`PIN_CHANGE_MASK_LO_IDX: read_value = pin_change_mask_lo;
			`PIN_CHANGE_MASK_HI_IDX: read_value = pin_change_mask_hi;
			`IRQ_STATUS_IDX:         read_value = irq_status;
			`IRQ_ENABLE_IDX:         read_value = irq_enable;
			default:                 read_value = 8'h00;
		endcase
	end

	// Read data is loaded at the address phase and stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (clk_en && addr_phase && !hwrite)
			hrdata <= {24'h00_0000, read_value};
	end

	// Software registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ext_irq_sense_ctrl <= `SENSE_CTRL_RESET;
		else if (wr_go && wr_index == `EXT_IRQ_SENSE_CTRL_IDX)
			ext_irq_sense_ctrl <= wr_byte & `SENSE_CTRL_WMASK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ext_irq_mask <= `EXT_IRQ_MASK_RESET;
		else if (wr_go && wr_index == `EXT_IRQ_MASK_IDX)
			ext_irq_mask <= wr_byte & `EXT_IRQ_MASK_WMASK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_change_mask_lo <= `PC_MASK_RESET;
			pin_change_mask_hi <= `PC_MASK_RESET;
		end else if (wr_go) begin
			if (wr_index == `PIN_CHANGE_MASK_LO_IDX)
				pin_change_mask_lo <= wr_byte;
			if (wr_index == `PIN_CHANGE_MASK_HI_IDX)
				pin_change_mask_hi <= wr_byte;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_enable <= `IRQ_ENABLE_RESET;
		else if (wr_go && wr_index == `IRQ_ENABLE_IDX)
			irq_enable <= wr_byte & `EXT_IRQ_MASK_WMASK;
	end

	// Detection

	assign sense_mode = sense_mode_t'(
		ext_irq_sense_ctrl[`SENSE_FIELD_W-1:0]);

	ext_pin_sense u_sense (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.clk_en      (clk_en),
		.pin         (ext_irq_zero),
		.mode        (sense_mode),
		.sense_event (zero_event)
	);

	// Port E lines feed in straight from the pad, bypassing any other use
	assign all_sources = {pin_change_source,
		port_e_bit2, port_e_bit1, port_e_bit0};
	assign pin_mask    = {pin_change_mask_hi, pin_change_mask_lo};

	pin_change_detect u_pc (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.clk_en        (clk_en),
		.pins          (all_sources),
		.pin_mask      (pin_mask),
		.group0_change (group0_change),
		.group1_change (group1_change)
	);

	// Sticky status; a set in the same cycle as a clear wins
	always_comb begin
		status_set = 8'h00;
		status_set[`EXT_IRQ_ZERO_BIT] = zero_event;
		status_set[`PC_GROUP0_BIT]    = group0_change;
		status_set[`PC_GROUP1_BIT]    = group1_change;
		status_clr = 8'h00;
		if (wr_go && wr_index == `IRQ_STATUS_IDX)
			status_clr = wr_byte;
		next_status = ((irq_status & ~status_clr) | status_set)
			& `EXT_IRQ_MASK_WMASK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_status <= `IRQ_STATUS_RESET;
		else if (clk_en)
			irq_status <= next_status;
	end

	// Low-level mode re-sets the flag each cycle the pin stays low, so
	// a release before acceptance leaves only the already-latched flag

	// Requests to the core

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_irq_zero_req         <= 1'b0;
			pin_change_group0_vector <= 1'b0;
			pin_change_group1_vector <= 1'b0;
		end else if (clk_en) begin
			ext_irq_zero_req <= global_irq_flag
				&& ext_irq_mask[`EXT_IRQ_ZERO_BIT]
				&& next_status[`EXT_IRQ_ZERO_BIT];
			pin_change_group0_vector <= global_irq_flag
				&& ext_irq_mask[`PC_GROUP0_BIT]
				&& next_status[`PC_GROUP0_BIT];
			pin_change_group1_vector <= global_irq_flag
				&& ext_irq_mask[`PC_GROUP1_BIT]
				&& next_status[`PC_GROUP1_BIT];
		end
	end

	// Software interrupt line, independent of the core's global flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(next_status & irq_enable);
	end
endmodule

// ---- inc/irq_sense_defs.svh ----
// Purpose: register map, field positions, reset values of the irq block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes:   printed offsets are word indices; byte address is four times
`ifndef IRQ_SENSE_DEFS_SVH
`define IRQ_SENSE_DEFS_SVH

`define EXT_IRQ_MASK_IDX        10'h01d
`define EXT_IRQ_SENSE_CTRL_IDX  10'h069
`define PIN_CHANGE_MASK_LO_IDX  10'h06b
`define PIN_CHANGE_MASK_HI_IDX  10'h06c
`define IRQ_STATUS_IDX          10'h070
`define IRQ_ENABLE_IDX          10'h071
`define ADDR_IDX_MSB            11
`define ADDR_IDX_LSB            2

`define EXT_IRQ_ZERO_BIT        0
`define PC_GROUP0_BIT           6
`define PC_GROUP1_BIT           7
`define SENSE_FIELD_W           2
`define EXT_IRQ_MASK_WMASK      8'hc1
`define SENSE_CTRL_WMASK        8'h03
`define EXT_IRQ_MASK_RESET      8'h00
`define SENSE_CTRL_RESET        8'h00
`define PC_MASK_RESET           8'h00
`define IRQ_STATUS_RESET        8'h00
`define IRQ_ENABLE_RESET        8'h00

`define PC_SOURCES              16
`define HTRANS_NONSEQ_BIT       1
`define HSIZE_WORD              3'h2
`define HRESP_OKAY              1'h0

`endif

// ---- inc/irq_sense_pkg.sv ----
// Purpose: shared types of the external irq and pin-change block
// Assumes: nothing beyond the defs header
// Notes:   sense codes match the two-bit control field
package irq_sense_pkg;

	typedef enum logic [1:0] {
		SENSE_LOW_LEVEL = 2'b00,
		SENSE_ANY_EDGE  = 2'b01,
		SENSE_FALLING   = 2'b10,
		SENSE_RISING    = 2'b11
	} sense_mode_t;

	typedef logic [7:0] reg_byte_t;

endpackage

// ---- verilog/ext_pin_sense.sv ----
// Purpose: synchronise the external irq pin and detect the chosen sense
// Assumes: pin is asynchronous to hclk
// Notes:   event is a registered pulse, or a level in low-level sense
`timescale 1ns/100ps
module ext_pin_sense
	import irq_sense_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        pin,
	input  wire sense_mode_t mode,
	output logic             sense_event
);
	logic sync_a;
	logic sync_b;
	logic prev;
	logic hit;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			prev   <= 1'b1;
		end else if (clk_en) begin
			sync_a <= pin;
			sync_b <= sync_a;
			prev   <= sync_b;
		end
	end

	// Edges come from sampled values only, so a pulse over one period is held
	always_comb begin
		unique case (mode)
			SENSE_LOW_LEVEL: hit = ~sync_b;
			SENSE_ANY_EDGE:  hit = sync_b ^ prev;
			SENSE_FALLING:   hit = prev & ~sync_b;
			SENSE_RISING:    hit = ~prev & sync_b;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sense_event <= 1'b0;
		else if (clk_en)
			sense_event <= hit;
	end
endmodule

// ---- verilog/pin_change_detect.sv ----
// Purpose: per-pin change detection for two groups of eight sources
// Assumes: pins asynchronous to hclk; masks come from hclk registers
// Notes:   outputs are registered one-cycle pulses per change
`timescale 1ns/100ps
`include "irq_sense_defs.svh"
module pin_change_detect
	import irq_sense_pkg::*;
(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     clk_en,
	input  wire logic [`PC_SOURCES-1:0]   pins,
	input  wire logic [`PC_SOURCES-1:0]   pin_mask,
	output logic                          group0_change,
	output logic                          group1_change
);
	logic [`PC_SOURCES-1:0] sync_a;
	logic [`PC_SOURCES-1:0] sync_b;
	logic [`PC_SOURCES-1:0] prev;
	logic [`PC_SOURCES-1:0] diff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_a <= '0;
			sync_b <= '0;
			prev   <= '0;
		end else if (clk_en) begin
			sync_a <= pins;
			sync_b <= sync_a;
			prev   <= sync_b;
		end
	end

	assign diff = (sync_b ^ prev) & pin_mask;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			group0_change <= 1'b0;
			group1_change <= 1'b0;
		end else if (clk_en) begin
			group0_change <= |diff[7:0];
			group1_change <= |diff[15:8];
		end
	end
endmodule

// ---- verification/ext_irq_ctrl_sva.sv ----
// Purpose: port-level checks of the irq sense block
// Assumes: one clock domain, hresetn asynchronous active low
// Notes:   bound into ext_irq_ctrl below
`timescale 1ns/100ps
module ext_irq_ctrl_sva
	import irq_sense_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        clk_en,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        port_e_bit0,
	input wire logic        port_e_bit1,
	input wire logic        port_e_bit2,
	input wire logic [15:3] pin_change_source,
	input wire logic        global_irq_flag,
	input wire logic        ext_irq_zero_req,
	input wire logic        pin_change_group0_vector,
	input wire logic        pin_change_group1_vector
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic [15:0] pins = {pin_change_source, port_e_bit2, port_e_bit1,
		port_e_bit0};
	wire logic rd_addr = hsel && htrans[1] && !hwrite && hready;
	wire logic wr_addr = hsel && htrans[1] && hwrite && hready;
	// Six quiet enabled cycles outlast the four-edge event latency
	sequence calm;
		($stable(pins) && global_irq_flag && clk_en && !wr_addr)[*6];
	endsequence
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_ready_high: assert property (hreadyout == 1'b1)
		else $error("wait state inserted");
	chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_rdata_hold: assert property (!rd_addr |=> $stable(hrdata))
		else $error("read data moved");
	chk_zero_gate: assert property (
		ext_irq_zero_req |-> $past(global_irq_flag))
		else $error("irq zero request without global flag");
	chk_grp0_gate: assert property (
		pin_change_group0_vector |-> $past(global_irq_flag))
		else $error("group 0 vector without global flag");
	chk_grp1_gate: assert property (
		pin_change_group1_vector |-> $past(global_irq_flag))
		else $error("group 1 vector without global flag");
	chk_change_calm: assert property (calm |=>
		!$rose(pin_change_group0_vector) &&
		!$rose(pin_change_group1_vector))
		else $error("group vector rose on quiet pins");
endmodule
bind ext_irq_ctrl ext_irq_ctrl_sva chk_u (.hclk, .hresetn, .clk_en, .hsel,
	.htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .port_e_bit0,
	.port_e_bit1, .port_e_bit2, .pin_change_source, .global_irq_flag,
	.ext_irq_zero_req, .pin_change_group0_vector, .pin_change_group1_vector);

// ---- verification/ext_pins_model.sv ----
// Purpose: off-chip drivers of the irq and pin-change pins
// Assumes: bench sets want right after a rising edge
// Notes:   pins move 2 ns after the edge, never on it
`timescale 1ns/100ps
module ext_pins_model (
	input  wire logic [16:0] want,
	input  wire logic        hclk,
	output logic             ext_irq_zero,
	output logic             port_e_bit0,
	output logic             port_e_bit1,
	output logic             port_e_bit2,
	output logic [15:3]      pin_change_source
);
	initial {ext_irq_zero, pin_change_source, port_e_bit2, port_e_bit1,
		port_e_bit0} = 17'h10000;
	// Levels held as long as commanded, low ones too
	always @(posedge hclk) begin
		#2;
		{ext_irq_zero, pin_change_source, port_e_bit2, port_e_bit1,
			port_e_bit0} = want;
	end
endmodule

// ---- verification/ext_irq_ctrl_bench.sv ----
// Purpose: self-checking bench of the irq sense block
// Assumes: zero wait-state slave, status latency under 8 edges
// Notes:   random pin toggles and masks from a fixed seed
`timescale 1ns/100ps
`include "irq_sense_defs.svh"
module ext_irq_ctrl_bench
	import irq_sense_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, glob, zreq, g0, g1, irq, e;
	logic        hreadyout, hresp, z, ce;
	logic [1:0]  htrans;
	logic [2:0]  hsize, pe;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:3] pcs;
	logic [16:0] want;
	logic [15:0] tog;
	logic [7:0]  mlo, mhi;
	integer      n_mismatch, checked, seed, i, j;

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	ext_irq_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_irq_zero(z),
		.port_e_bit0(pe[0]), .port_e_bit1(pe[1]), .port_e_bit2(pe[2]),
		.pin_change_source(pcs), .global_irq_flag(glob),
		.ext_irq_zero_req(zreq), .pin_change_group0_vector(g0),
		.pin_change_group1_vector(g1), .irq(irq));
	ext_pins_model pins_u (.want(want), .hclk(hclk), .ext_irq_zero(z),
		.port_e_bit0(pe[0]), .port_e_bit1(pe[1]), .port_e_bit2(pe[2]),
		.pin_change_source(pcs));

	task check(input string name, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {20'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	function automatic logic fires(input logic [1:0] m, input logic b, a);
		case (m)
		2'b00: return !(b && a);
		2'b01: return b != a;
		2'b10: return b && !a;
		default: return !b && a;
		endcase
	endfunction
	task settle;
		repeat (8) @(posedge hclk);
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		summarize;
	end
	initial begin
		n_mismatch = 0;
		checked = 0;
		seed = 32'hf58d;
		{hresetn, hsel, htrans, hwrite, glob, haddr, hwdata} = '0;
		hsize = `HSIZE_WORD;
		ce = 1'b1;
		want = 17'h10000;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, `EXT_IRQ_MASK_IDX, 32'h0);
		check("mask reset", rd, 32'h0);
		bus(1'b0, `EXT_IRQ_SENSE_CTRL_IDX, 32'h0);
		check("sense reset", rd, 32'h0);
		bus(1'b1, `EXT_IRQ_MASK_IDX, 32'hffffffff);
		bus(1'b0, `EXT_IRQ_MASK_IDX, 32'h0);
		check("mask bits", rd, 32'hc1);
		bus(1'b1, `EXT_IRQ_SENSE_CTRL_IDX, 32'hffffffff);
		bus(1'b0, `EXT_IRQ_SENSE_CTRL_IDX, 32'h0);
		check("sense bits", rd, 32'h03);
		bus(1'b0, 10'h3ff, 32'h0);
		check("unmapped", rd, 32'h0);
		bus(1'b1, `IRQ_ENABLE_IDX, 32'hc1);
		glob <= 1'b1;
		$display("test registers done");
		for (i = 0; i < 8; i++) begin
			e = fires(i[2:1], i[0], !i[0]);
			bus(1'b1, `EXT_IRQ_SENSE_CTRL_IDX, 32'(i[2:1]));
			want[16] <= i[0];
			settle;
			bus(1'b1, `IRQ_STATUS_IDX, 32'h01);
			want[16] <= !i[0];
			settle;
			bus(1'b0, `IRQ_STATUS_IDX, 32'h0);
			check("ext status", 32'(rd[0]), 32'(e));
			check("ext request", 32'(zreq), 32'(e));
			check("irq line", 32'(irq), 32'(e));
		end
		// Short pulse in rising mode must still be caught
		bus(1'b1, `IRQ_STATUS_IDX, 32'h01);
		want[16] <= 1'b1;
		repeat (2) @(posedge hclk);
		want[16] <= 1'b0;
		settle;
		bus(1'b0, `IRQ_STATUS_IDX, 32'h0);
		check("pulse", 32'(rd[0]), 32'h1);
		bus(1'b1, `IRQ_ENABLE_IDX, 32'h0);
		glob <= 1'b0;
		repeat (2) @(posedge hclk);
		check("irq masked", 32'(irq), 32'h0);
		check("global off", 32'(zreq), 32'h0);
		glob <= 1'b1;
		bus(1'b1, `IRQ_ENABLE_IDX, 32'hc1);
		$display("test irq zero done");
		for (j = 0; j < 24; j++) begin
			mlo = 8'($random(seed));
			mhi = 8'($random(seed));
			tog = 16'($random(seed));
			if (j < 3) begin
				tog = 16'(1 << j);
				mlo = 8'(1 << j);
			end
			bus(1'b1, `PIN_CHANGE_MASK_LO_IDX, {24'h0, mlo});
			bus(1'b1, `PIN_CHANGE_MASK_HI_IDX, {24'h0, mhi});
			settle;
			bus(1'b1, `IRQ_STATUS_IDX, 32'hc1);
			want[15:0] <= want[15:0] ^ tog;
			settle;
			bus(1'b0, `IRQ_STATUS_IDX, 32'h0);
			check("group status", rd, {24'h0, |(tog[15:8] & mhi),
				|(tog[7:0] & mlo), 6'h0});
			check("group vectors", 32'({g1, g0}), 32'({|(tog[15:8] & mhi),
				|(tog[7:0] & mlo)}));
		end
		// A frozen block must not see a pin change until enabled again
		bus(1'b1, `PIN_CHANGE_MASK_LO_IDX, 32'h01);
		bus(1'b1, `IRQ_STATUS_IDX, 32'hc1);
		ce <= 1'b0;
		want[0] <= !want[0];
		settle;
		check("frozen vector", 32'(g0), 32'h0);
		ce <= 1'b1;
		settle;
		check("thawed vector", 32'(g0), 32'h1);
		$display("test pin change done");
		summarize;
	end
endmodule
